// >>> verilog/mux_out_pkg.sv
// Package with register map, field layouts and timing constants of the strobed output port
package mux_out_pkg;
  // Register byte offsets
  localparam logic [7:0] output_word_reference_0 = 8'h00;  // Channel select word
  localparam logic [7:0] output_word_reference_1 = 8'h04;  // Data word, launches transfer
  localparam logic [7:0] input_word_reference    = 8'h08;  // Channel echo word
  localparam logic [7:0] multiplexed_output_config = 8'h0c;
  localparam logic [7:0] status_reg              = 8'h10;
  // Config fields
  localparam int cfg_bcd_bit       = 0;
  localparam int cfg_strobe_hi_bit = 1;
  localparam int cfg_map_bcd_bit   = 2;
  localparam int cfg_word_map_bit  = 3;
  localparam logic [3:0] cfg_reset = 4'h0;  // Binary, true-low, binary map, bit mapping
  // Status fields
  localparam int st_busy_bit  = 0;
  localparam int st_err_bit   = 1;
  localparam int st_valid_bit = 2;
  localparam int st_level_lsb = 8;
  // Widths
  localparam int channels   = 8;
  localparam int data_width = 16;
  localparam int chan_width = 3;
  // Timing
  localparam int clk_mhz        = 100;
  localparam int strobe_us      = 200;
  localparam int strobe_cycles  = strobe_us * clk_mhz;
  localparam int setup_us       = 2;
  localparam int setup_cycles   = setup_us * clk_mhz;
  localparam int response_us    = 11300;
  localparam int response_cycles = response_us * clk_mhz;
  localparam int fifo_depth     = 16;
  typedef enum logic [1:0] {
    st_idle   = 2'b00,
    st_setup  = 2'b01,
    st_strobe = 2'b10,
    st_hold   = 2'b11
  } xfer_state_t;
endpackage

// >>> verilog/fifo_if.sv
// Interface carrying one FIFO port pair between the port logic and the queue
`timescale 1ns/1ns
`default_nettype none
interface fifo_if #(parameter int width = 19);
  logic             in_valid;
  logic             in_ready;
  logic [width-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [width-1:0] out_data;
  modport writer (output in_valid, output in_data, input in_ready,
                  input out_valid, input out_data, output out_ready);
  modport queue  (input in_valid, input in_data, output in_ready,
                  output out_valid, output out_data, input out_ready);
endinterface
`default_nettype wire

// >>> verilog/xfer_fifo.sv
// Parameterised synchronous FIFO holding pending channel transfers
`timescale 1ns/1ns
`default_nettype none
module xfer_fifo #(
  parameter int width = 19,
  parameter int depth = 16
) (
  input  wire logic pclk,
  input  wire logic presetn,
  fifo_if.queue     port,
  output logic [$clog2(depth):0] level
);
  localparam int aw = $clog2(depth);
  logic [width-1:0] mem [depth];
  logic [aw-1:0]    wr_ptr;
  logic [aw-1:0]    rd_ptr;
  logic [aw:0]      count;
  logic             do_wr;
  logic             do_rd;

  assign port.in_ready  = (count != depth[aw:0]);
  assign port.out_valid = (count != '0);
  assign port.out_data  = mem[rd_ptr];
  assign do_wr = port.in_valid & port.in_ready;
  assign do_rd = port.out_valid & port.out_ready;
  assign level = count;

  // Storage write, no reset needed for the array
  always_ff @(posedge pclk) begin
    if (do_wr) begin
      mem[wr_ptr] <= port.in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == aw'(depth - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == aw'(depth - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (aw+1)'(do_wr) - (aw+1)'(do_rd);
    end
  end
endmodule
`default_nettype wire

// >>> verilog/strobed_register_output_mux.sv
// Strobed eight-channel register output port with APB register access
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module strobed_register_output_mux #(
  parameter int strobe_len  = mux_out_pkg::strobe_cycles,
  parameter int setup_len   = mux_out_pkg::setup_cycles,
  parameter int queue_depth = mux_out_pkg::fifo_depth
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [15:0]      field_data,
  output logic             field_data_oe,
  output logic [7:0]       field_strobe,
  output logic             format_is_bcd,
  output logic             format_error
);
  import mux_out_pkg::*;

  localparam int fw = chan_width + data_width;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [15:0]             chan_word;
  logic [15:0]             data_word;
  logic [3:0]              cfg;
  logic [chan_width-1:0]   echo_chan;
  logic                    echo_valid;
  logic                    xfer_err;
  logic                    wr_go;
  logic                    rd_go;
  logic                    data_hit;
  logic [$clog2(queue_depth):0] q_level;
  xfer_state_t             state;
  logic [chan_width-1:0]   cur_chan;
  logic [31:0]             timer;
  logic                    timer_done;
  fifo_if #(.width(fw))    q ();

  // Write data with byte enables applied onto a 32-bit image
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Address decode used by both write and read paths
  function automatic logic mapped(input logic [7:0] a);
    return a == output_word_reference_0 || a == output_word_reference_1 ||
           a == input_word_reference || a == multiplexed_output_config || a == status_reg;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: single-cycle access, except a data write waits for queue room
  assign data_hit = psel && pwrite && paddr == output_word_reference_1;
  assign pready   = !(data_hit && !q.in_ready);     // Back-pressure from the queue
  assign pslverr  = psel && penable && !mapped(paddr);
  assign wr_go    = psel && penable && pready && pwrite && mapped(paddr);
  assign rd_go    = psel && !penable && !pwrite;

  // Host image: select word then data word, 32 bits in total
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_word <= '0;
      data_word <= '0;
    end else if (wr_go && paddr == output_word_reference_0) begin
      chan_word <= 16'(merge({16'h0000, chan_word}, pwdata, pstrb));
    end else if (wr_go && paddr == output_word_reference_1) begin
      data_word <= 16'(merge({16'h0000, data_word}, pwdata, pstrb));
    end
  end

  // Format and polarity switches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= cfg_reset;
    end else if (wr_go && paddr == multiplexed_output_config) begin
      cfg <= 4'(merge({28'h0, cfg}, pwdata, pstrb));
    end
  end

  // Host map format against module format; BCD on both is flagged
  assign format_is_bcd = cfg[cfg_bcd_bit] ^ cfg[cfg_map_bcd_bit];
  assign format_error  = cfg[cfg_bcd_bit] & cfg[cfg_map_bcd_bit];

  // Queue a transfer on the data word write: one channel per host cycle
  assign q.in_valid = wr_go && paddr == output_word_reference_1;
  assign q.in_data  = {chan_word[chan_width-1:0],
                       16'(merge({16'h0000, data_word}, pwdata, pstrb))};

  // Read mux, registered at setup so data stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_go) begin
      unique case (paddr)
        output_word_reference_0:   prdata <= {16'h0000, chan_word};
        output_word_reference_1:   prdata <= {16'h0000, data_word};
        // Echo word is 16 bits wide
        input_word_reference:      prdata <= {16'h0000, 13'h0000, echo_chan};
        multiplexed_output_config: prdata <= {28'h0, cfg};
        status_reg: begin
          prdata <= '0;
          prdata[st_busy_bit]  <= state != st_idle || q.out_valid;
          prdata[st_err_bit]   <= xfer_err;
          prdata[st_valid_bit] <= echo_valid;
          prdata[st_level_lsb +: 8] <= 8'(q_level);
        end
        default:                   prdata <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending transfers; the queue stalls the bus when full
  xfer_fifo #(.width(fw), .depth(queue_depth)) u_queue (
    .pclk    (pclk),
    .presetn (presetn),
    .port    (q.queue),
    .level   (q_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Field sequencer: present data, strobe, hold
  assign timer_done   = (timer == '0);
  assign q.out_ready  = (state == st_idle);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= st_idle;
      timer      <= '0;
      cur_chan   <= '0;
      field_data <= '0;
    end else begin
      unique case (state)
        st_idle: begin
          if (q.out_valid) begin
            // Shared data lines, channel picked only by its strobe
            field_data <= q.out_data[data_width-1:0];
            cur_chan   <= q.out_data[fw-1 -: chan_width];
            timer      <= 32'(setup_len - 1);
            state      <= st_setup;
          end
        end
        st_setup: begin
          if (timer_done) begin
            timer <= 32'(strobe_len - 1);  // 200 us pulse
            state <= st_strobe;
          end else begin
            timer <= timer - 1'b1;
          end
        end
        st_strobe: begin
          if (timer_done) begin
            timer <= 32'(setup_len - 1);
            state <= st_hold;
          end else begin
            timer <= timer - 1'b1;
          end
        end
        st_hold: begin
          // Data held after strobe so the target latches clean values
          if (timer_done) begin
            state <= st_idle;
          end else begin
            timer <= timer - 1'b1;
          end
        end
      endcase
    end
  end

  // Strobe lines with selected polarity, data frozen across the pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      field_strobe <= '1;  // Idle high matches the true-low reset setting
    end else begin
      for (int i = 0; i < channels; i++) begin
        field_strobe[i] <= ((state == st_strobe) && cur_chan == chan_width'(i)) ^
                           !cfg[cfg_strobe_hi_bit];
      end
    end
  end

  assign field_data_oe = presetn;  // Data lines always driven while out of reset

  // Echo the finished channel; about 0.2 ms per entry, so a full queue meets 11.3 ms
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      echo_chan  <= '0;
      echo_valid <= 1'b0;
    end else if (state == st_strobe && timer_done) begin
      echo_chan  <= cur_chan;
      echo_valid <= 1'b1;
    end
  end

  // Sticky error: a transfer sent while the format pair is erroneous or data out of BCD range
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_err <= 1'b0;
    end else if (state == st_idle && q.out_valid && (format_error ||
                 (format_is_bcd && q.out_data[15:0] > 16'h9999))) begin
      xfer_err <= 1'b1;  // Set wins over clear
    end else if (wr_go && paddr == status_reg && pwdata[st_err_bit]) begin
      xfer_err <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> sim/strobed_register_output_mux_properties.sv
// Port-level assertions for the strobed output port
`timescale 1ns/1ns
`default_nettype none
module mux_port_checker #(
  parameter int strobe_len = 20
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] field_data,
  input wire logic        field_data_oe,
  input wire logic [7:0]  field_strobe,
  input wire logic        format_is_bcd,
  input wire logic        format_error
);
  logic        strobing;
  logic        acc;
  logic [15:0] run_len;
  // Idle level is unseen here, so a pulse is one line differing from the rest
  assign strobing = (|field_strobe) && !(&field_strobe);
  assign acc      = psel && penable && pready;
  // Cycles spent in the current pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_len <= 16'h0000;
    end else begin
      run_len <= strobing ? run_len + 16'h0001 : 16'h0000;
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_one_strobe: assert property ($onehot0(field_strobe) || $onehot0(~field_strobe))
    else $error("two strobes active");
  a_pulse_len: assert property ($fell(strobing) |-> run_len == strobe_len)
    else $error("strobe pulse length wrong");
  a_pulse_cap: assert property (strobing |-> run_len < strobe_len)
    else $error("strobe pulse too long");
  a_data_hold: assert property (strobing |-> $stable(field_data))
    else $error("data moved under strobe");
  a_update_due: assert property (acc && pwrite && paddr == 8'h04 |-> ##[1:1000] strobing)
    else $error("no field update");
  a_format_err: assert property (format_error |-> !format_is_bcd)
    else $error("error format marked bcd");
  a_no_wait: assert property (psel && penable && !(pwrite && paddr == 8'h04) |-> pready)
    else $error("unexpected wait state");
  a_bad_addr: assert property (acc && (paddr > 8'h10 || paddr[1:0] != 2'b00)
    |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_drive_on: assert property (field_data_oe)
    else $error("data lines released");
  c_pulse: cover property ($fell(strobing));
  c_stall: cover property (psel && penable && !pready);
  c_err: cover property (format_error);
endmodule
bind strobed_register_output_mux mux_port_checker #(.strobe_len(strobe_len)) checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .field_data(field_data), .field_data_oe(field_data_oe),
  .field_strobe(field_strobe), .format_is_bcd(format_is_bcd), .format_error(format_error));
`default_nettype wire

// >>> sim/field_device_bank.sv
// Model of the eight field devices sharing the data lines
`timescale 1ns/1ns
`default_nettype none
module field_device_bank (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [15:0] field_data,
  input  wire logic [7:0]  field_strobe,
  input  wire logic        active_high,
  output var  logic [2:0]  last_chan,
  output var  logic [15:0] last_data,
  output var  int          seen
);
  logic [7:0] active;
  logic [7:0] was_active;
  // Each device follows its own strobe line and needs all other lines idle, at the chosen polarity
  assign active = active_high ? field_strobe : ~field_strobe;
  // Latch on the trailing edge; a lone pulse only, so polarity flips are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      was_active <= 8'h00;
      last_chan  <= 3'h0;
      last_data  <= 16'h0000;
      seen       <= 0;
    end else begin
      was_active <= active;
      for (int i = 0; i < 8; i++) begin
        if (was_active == (8'h01 << i) && !active[i]) begin
          last_chan <= 3'(i);
          last_data <= field_data;
          seen      <= seen + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> sim/test_strobed_register_output_mux.sv
// Self-checking testbench for the strobed output port
`timescale 1ns/1ns
`default_nettype none
`define check(got, exp) begin total_checks++; if ((got) !== (exp)) begin failures++; \
  $display("BAD %0t got %h want %h", $time, got, exp); end end
module test_strobed_register_output_mux;
  import mux_out_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic        field_data_oe, format_is_bcd, format_error, active_high;
  logic [7:0]  paddr, field_strobe;
  logic [31:0] pwdata, prdata, rdata;
  logic [15:0] field_data, last_data;
  logic [2:0]  last_chan;
  int          seen, waited, failures, total_checks;
  strobed_register_output_mux #(.strobe_len(20), .setup_len(3), .queue_depth(fifo_depth)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .field_data(field_data), .field_data_oe(field_data_oe),
    .field_strobe(field_strobe), .format_is_bcd(format_is_bcd), .format_error(format_error));
  field_device_bank model (.pclk(pclk), .presetn(presetn), .field_data(field_data),
    .field_strobe(field_strobe), .active_high(active_high), .last_chan(last_chan),
    .last_data(last_data), .seen(seen));
  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // One APB transfer; holds the request until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    waited = 0;
    // Pready is looked at mid-cycle, where it has settled for the coming edge
    @(negedge pclk);
    while (pready !== 1'b1 && waited < 2000) begin
      @(negedge pclk);
      waited++;
    end
    rdata = prdata;
    rerr  = pslverr;
    @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (waited >= 2000) begin
      failures++;
      complete_run();
    end
  endtask
  task automatic wait_seen(input int n);
    for (int i = 0; i < 2000 && seen < n; i++) @(posedge pclk);
    if (seen < n) begin
      failures++;
      complete_run();
    end
  endtask
  // Channel word first, data word second, then the echo is read back
  task automatic send(input logic [2:0] c, input logic [15:0] d);
    int n;
    n = seen;
    apb(1'b1, output_word_reference_0, {29'h0, c});
    apb(1'b1, output_word_reference_1, {16'h0, d});
    wait_seen(n + 1);
    `check(last_chan, c)
    `check(last_data, d)
    apb(1'b0, input_word_reference, 32'h0);
    `check(rdata[2:0], c)
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    `check(field_strobe, 8'hff)
    apb(1'b0, multiplexed_output_config, 32'h0);
    `check(rdata[3:0], cfg_reset)
    $display("test reset done");
  endtask
  task automatic t_channels();
    for (int c = 0; c < 8; c++) send(3'(c), 16'hfff0 + 16'(c));
    $display("test channels done");
  endtask
  task automatic t_polarity();
    apb(1'b1, multiplexed_output_config, 32'h2);
    active_high <= 1'b1;
    repeat (2) @(posedge pclk);
    `check(field_strobe, 8'h00)
    send(3'd7, 16'h0000);
    apb(1'b1, multiplexed_output_config, 32'h0);
    active_high <= 1'b0;
    $display("test polarity done");
  endtask
  // Map format in bit 2, module format in bit 0, all four pairings
  task automatic t_formats();
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, multiplexed_output_config, {29'h0, i[1], 1'b0, i[0]});
      @(posedge pclk);
      `check(format_is_bcd, logic'(i[0] ^ i[1]))
      `check(format_error, logic'(i[0] & i[1]))
      if (i == 1) send(3'd2, 16'h9999);
    end
    apb(1'b1, multiplexed_output_config, 32'h0);
    $display("test formats done");
  endtask
  task automatic t_unmapped();
    apb(1'b1, 8'h20, 32'hffff_ffff);
    `check(rerr, 1'b1)
    apb(1'b0, 8'h20, 32'h0);
    `check(rerr, 1'b1)
    `check(rdata, 32'h0)
    $display("test unmapped done");
  endtask
  // Overrun the queue so a data write must wait, then drain it
  task automatic t_queue();
    int n;
    int most;
    n = seen;
    most = 0;
    apb(1'b1, output_word_reference_0, 32'h3);
    for (int k = 0; k < 21; k++) begin
      apb(1'b1, output_word_reference_1, 32'h0100 + k);
      if (waited > most) most = waited;
    end
    `check(most > 1, 1'b1)
    wait_seen(n + 21);
    `check(last_data, 16'h0114)
    apb(1'b0, status_reg, 32'h0);
    `check(rdata[15:8], 8'h00)
    $display("test queue done");
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    active_high = 1'b0;
    failures = 0;
    total_checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_channels();
    t_polarity();
    t_formats();
    t_unmapped();
    t_queue();
    complete_run();
  end
endmodule
`default_nettype wire
